//--- dv/cfg_one_test.sv
// self-checking bench for configuration register one
`timescale 1ns/1ps
`define CHK(got, exp) check(8'(got), 8'(exp))
module cfg_one_test
  import cfg_one_pkg::*;
;
  logic       clock;
  logic       rst;
  logic       hw_reset;
  logic       soft_reset;
  logic       sck;
  logic       cs_n;
  logic       data_in;
  logic       wp_n;
  logic       pause_n;
  logic [7:0] read_opcode;
  logic       data_out;
  logic       data_out_en;
  logic [7:0] config_reg_one;
  logic [2:0] protect_range_bits;
  logic       program_error_flag;
  logic       busy_flag;
  logic [3:0] mode_cycles;
  logic [3:0] dummy_cycles;
  logic       pattern_allowed;
  logic       protect_from_top;
  logic       small_sectors_top;
  logic       wp_active;
  logic       pause_active;
  int         mismatches;
  int         samples_checked;
  logic [23:0] r;
  logic [7:0] rv;
  logic       ren;
  logic [7:0] e_cfg;
  logic [3:0] e_mode;
  logic [3:0] e_dummy;
  logic       e_sst;
  logic       e_err;

  // row: variant (bit 22 = enhanced), latency code, opcode, mode, dummy,
  // pattern (f = not checked)
  localparam logic [23:0] ROWS [64] = '{
    24'h30300f, 24'h33b00f, 24'h36b00f, 24'h3bb04f,
    24'h3eb21f, 24'h30d040, 24'h3bd040, 24'h3ed130,
    24'h00b08f, 24'h03b08f, 24'h06b08f, 24'h0bb04f,
    24'h0eb24f, 24'h00d051, 24'h0bd061, 24'h0ed161,
    24'h10c08f, 24'h13c08f, 24'h16c08f, 24'h1bc05f,
    24'h1ec24f, 24'h10e061, 24'h1be071, 24'h1ee171,
    24'h20b08f, 24'h23b08f, 24'h26b08f, 24'h2bb06f,
    24'h2eb25f, 24'h20d071, 24'h2bd081, 24'h2ed181,
    24'h7bb40f, 24'h70d41f, 24'h7bd22f, 24'h7ed13f,
    24'h7eb21f, 24'h76b00f, 24'h70b00f, 24'h73b00f,
    24'h4bb40f, 24'h40d42f, 24'h4bd24f, 24'h4ed16f,
    24'h4eb24f, 24'h46b08f, 24'h40b08f, 24'h43b08f,
    24'h5bb41f, 24'h50d44f, 24'h5bd25f, 24'h5ed17f,
    24'h5eb24f, 24'h56b08f, 24'h50b08f, 24'h53b08f,
    24'h6bb42f, 24'h60d45f, 24'h6bd26f, 24'h6ed18f,
    24'h6eb25f, 24'h66b08f, 24'h60b08f, 24'h63b08f};

  localparam logic [7:0] DDR_OPC [3] = '{OPC_DFAST, OPC_DDIO, OPC_DQIO};

  cfg_one #(.ENHANCED(1'b0), .UNIFORM(1'b0)) i_cfg_one (
    .clock               (clock),
    .rst                 (rst),
    .hw_reset            (hw_reset),
    .soft_reset          (soft_reset),
    .sck                 (sck),
    .cs_n                (cs_n),
    .data_in             (data_in),
    .write_protect_pin_n (wp_n),
    .pause_pin_n         (pause_n),
    .read_opcode         (read_opcode),
    .data_out            (data_out),
    .data_out_en         (data_out_en),
    .config_reg_one      (config_reg_one),
    .protect_range_bits  (protect_range_bits),
    .program_error_flag  (program_error_flag),
    .busy_flag           (busy_flag),
    .mode_cycles         (mode_cycles),
    .dummy_cycles        (dummy_cycles),
    .pattern_allowed     (pattern_allowed),
    .protect_from_top    (protect_from_top),
    .small_sectors_top   (small_sectors_top),
    .wp_active           (wp_active),
    .pause_active        (pause_active)
  );

  // second copy on the same link: enhanced latency, uniform sector map
  cfg_one #(.ENHANCED(1'b1), .UNIFORM(1'b1)) i_cfg_one_enh (
    .clock               (clock),
    .rst                 (rst),
    .hw_reset            (hw_reset),
    .soft_reset          (soft_reset),
    .sck                 (sck),
    .cs_n                (cs_n),
    .data_in             (data_in),
    .write_protect_pin_n (wp_n),
    .pause_pin_n         (pause_n),
    .read_opcode         (read_opcode),
    .data_out            (),
    .data_out_en         (),
    .config_reg_one      (e_cfg),
    .protect_range_bits  (),
    .program_error_flag  (e_err),
    .busy_flag           (),
    .mode_cycles         (e_mode),
    .dummy_cycles        (e_dummy),
    .pattern_allowed     (),
    .protect_from_top    (),
    .small_sectors_top   (e_sst),
    .wp_active           (),
    .pause_active        ()
  );

  spi_host_model i_spi_host_model (
    .sck         (sck),
    .cs_n        (cs_n),
    .data_in     (data_in),
    .data_out    (data_out),
    .data_out_en (data_out_en)
  );

  always #20 clock = ~clock;

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask

  // the frame ends well after the two-clock update; a few clocks spare
  task automatic wr(input logic [7:0] st, input logic [7:0] cfg);
    i_spi_host_model.write_regs(st, cfg);
    tick(4);
  endtask

  task automatic do_rst();
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(1);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    hw_reset = 1'b0;
    soft_reset = 1'b0;
    wp_n = 1'b1;
    pause_n = 1'b1;
    read_opcode = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    do_rst();
    `CHK(config_reg_one, CFG_RESET);
    `CHK(protect_from_top, 1'b1);
    `CHK(small_sectors_top, 1'b0);
    for (int i = 0; i < 64; i++) begin
      r = ROWS[i];
      if (i % 8 == 0) begin
        wr(8'h00, {r[21:20], 6'h00});
        `CHK(config_reg_one, {r[21:20], 6'h00});
      end
      read_opcode = r[19:12];
      tick(2);
      if (r[22]) begin
        `CHK(e_mode, r[11:8]);
        `CHK(e_dummy, r[7:4]);
      end else begin
        `CHK(mode_cycles, r[11:8]);
        `CHK(dummy_cycles, r[7:4]);
        if (r[3:0] != 4'hf) `CHK(pattern_allowed, r[0]);
      end
    end
    // the codes a host picks for the pattern leave room for it
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, {i_spi_host_model.advised_lc(DDR_OPC[k]), 6'h00});
      read_opcode = DDR_OPC[k];
      tick(2);
      `CHK(pattern_allowed, 1'b1);
      `CHK(dummy_cycles >= PATTERN_MIN_DUMMY, 1'b1);
    end
    // one-time bits: set, refused clear, busy lock-out, clear status
    do_rst();
    wp_n = 1'b0;
    pause_n = 1'b0;
    tick(6);
    `CHK({wp_active, pause_active}, 2'b11);
    wr(8'h00, 8'h20);
    `CHK(protect_from_top, 1'b0);
    wr(8'h00, 8'h00);
    `CHK(config_reg_one, 8'h20);
    `CHK({program_error_flag, busy_flag}, 2'b11);
    wr(8'h00, 8'h24);
    `CHK(config_reg_one, 8'h20);
    i_spi_host_model.clear_status();
    tick(4);
    `CHK({program_error_flag, busy_flag}, 2'b00);
    wr(8'h00, 8'h24);
    `CHK(small_sectors_top, 1'b1);
    `CHK(e_sst, 1'b0);
    `CHK(e_cfg, 8'h20);
    wr(8'h00, 8'h20);
    `CHK(config_reg_one, 8'h24);
    `CHK(program_error_flag, 1'b1);
    `CHK(e_err, 1'b0);
    // volatile range bits come back as all ones after a soft reset
    do_rst();
    wr(8'h08, 8'h08);
    `CHK(protect_range_bits, 3'h2);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(2);
    `CHK(protect_range_bits, PROT_VOL_RST);
    wr(8'h00, 8'h00);
    `CHK(program_error_flag, 1'b1);
    // freeze set together with latency and quad in one write
    do_rst();
    wr(8'h04, 8'hc3);
    `CHK(config_reg_one, 8'hc3);
    `CHK({wp_active, pause_active}, 2'b00);
    i_spi_host_model.read_cfg(rv, ren);
    tick(4);
    `CHK(rv, 8'hc3);
    `CHK(ren, 1'b1);
    `CHK(data_out_en, 1'b0);
    wr(8'h1c, 8'he3);
    `CHK(config_reg_one, 8'hc3);
    `CHK(protect_range_bits, 3'h1);
    soft_reset = 1'b1;
    tick(1);
    soft_reset = 1'b0;
    tick(2);
    `CHK(config_reg_one[FRZ_B], 1'b1);
    `CHK(protect_range_bits, 3'h1);
    hw_reset = 1'b1;
    tick(1);
    hw_reset = 1'b0;
    tick(2);
    `CHK(config_reg_one[FRZ_B], 1'b0);
    wr(8'h1c, 8'hc2);
    `CHK(protect_range_bits, 3'h7);
    tally_and_finish();
  end
endmodule

//--- dv/spi_host_model.sv
// host-side link driver: frames commands on select, clock and data lines
`timescale 1ns/1ps
module spi_host_model
  import cfg_one_pkg::*;
(
  output logic sck,
  output logic cs_n,
  output logic data_in,
  input  logic data_out,
  input  logic data_out_en
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    data_in = 1'b0;
  end

  // link clock rests low between frames; a released data line shows the
  // inverse of its last bit so a stale value cannot pass for a good one.
  // only serial-width frames go out, never a quad command
  task automatic frame(input logic [23:0] bits, input int n);
    #13;
    cs_n = 1'b0;
    #160;
    for (int i = 23; i > 23 - n; i--) begin
      data_in = bits[i];
      #160 sck = 1'b1;
      #160 sck = 1'b0;
    end
    #160 cs_n = 1'b1;
    data_in = ~data_in;
  endtask

  // status byte then config byte; issued on a blank array only, since
  // no array program or erase ever goes out from here
  task automatic write_regs(input logic [7:0] st, input logic [7:0] cfg);
    frame({WRITE_REGS_OPC, st, cfg}, 24);
  endtask

  task automatic clear_status();
    frame({CLEAR_STATUS_OPC, 16'h0000}, 8);
  endtask

  // read-back: the device shifts on falling edges, the host takes each
  // bit on the next rising edge, so the first bit lands on rise nine
  task automatic read_cfg(output logic [7:0] v, output logic en);
    v = 8'h00;
    en = 1'b1;
    #13;
    cs_n = 1'b0;
    #160;
    for (int i = 15; i >= 0; i--) begin
      data_in = (i > 7) ? READ_CFG_OPC[i - 8] : 1'b0;
      #160 sck = 1'b1;
      if (i < 8) begin
        v[i] = data_out;
        en   = en & data_out_en;
      end
      #160 sck = 1'b0;
    end
    #160 cs_n = 1'b1;
    data_in = ~data_in;
  endtask

  // pattern in use: codes with five or more dummy cycles, so the host
  // lets go of the lines a cycle early
  function automatic logic [1:0] advised_lc(input logic [7:0] opc);
    case (opc)
      OPC_DFAST, OPC_DFAST4: return 2'b10;
      OPC_DDIO, OPC_DDIO4:   return 2'b01;
      default:               return 2'b00;
    endcase
  endfunction
endmodule

//--- rtl/cfg_one.sv
// configuration register one: latency lookup, protection bits, quad, freeze
`timescale 1ns/1ps
module cfg_one
  import cfg_one_pkg::*;
#(
  parameter bit ENHANCED = 1'b0,
  parameter bit UNIFORM  = 1'b0
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       hw_reset,
  input  wire logic       soft_reset,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       data_in,
  input  wire logic       write_protect_pin_n,
  input  wire logic       pause_pin_n,
  input  wire logic [7:0] read_opcode,
  output logic            data_out,
  output logic            data_out_en,
  output logic [7:0]      config_reg_one,
  output logic [2:0]      protect_range_bits,
  output logic            program_error_flag,
  output logic            busy_flag,
  output logic [3:0]      mode_cycles,
  output logic [3:0]      dummy_cycles,
  output logic            pattern_allowed,
  output logic            protect_from_top,
  output logic            small_sectors_top,
  output logic            wp_active,
  output logic            pause_active
);

  // latency lookup, index 0..3 for codes 11,00,01,10
  function automatic logic [1:0] lc_idx(input logic [1:0] lc);
    lc_idx = lc + 2'h1;
  endfunction

  function automatic latency_t lookup(input logic [7:0] opc,
                                      input logic [1:0] lc,
                                      input bit enh);
    logic [1:0] i;
    latency_t r;
    i = lc_idx(lc);
    r = '{mode: 4'h0, dummy: 4'h0, pattern_ok: 1'b0};
    unique case (opc)
      OPC_READ, OPC_READ4:
        r.dummy = 4'h0;
      OPC_FAST, OPC_FAST4, OPC_DOUT, OPC_DOUT4, OPC_QOUT, OPC_QOUT4:
        r.dummy = (i == 2'h0) ? 4'h0 : 4'h8;
      OPC_DIO, OPC_DIO4:
        if (enh) begin
          r.mode  = 4'h4;
          r.dummy = (i < 2'h2) ? 4'h0 : {2'h0, i - 2'h1};
        end else begin
          r.dummy = (i < 2'h2) ? 4'h4 : {2'h0, i} + 4'h3;
        end
      OPC_QIO, OPC_QIO4: begin
        r.mode = 4'h2;
        unique case (i)
          2'h0:    r.dummy = 4'h1;
          2'h3:    r.dummy = 4'h5;
          default: r.dummy = 4'h4;
        endcase
      end
      OPC_DFAST, OPC_DFAST4:
        if (enh) begin
          r.mode = 4'h4;
          unique case (i)
            2'h0: r.dummy = 4'h1;
            2'h1: r.dummy = 4'h2;
            2'h2: r.dummy = 4'h4;
            2'h3: r.dummy = 4'h5;
          endcase
        end else begin
          r.dummy = {2'h0, i} + 4'h4;
        end
      OPC_DDIO, OPC_DDIO4:
        if (enh) begin
          r.mode  = 4'h2;
          r.dummy = (i == 2'h0) ? 4'h2 : {2'h0, i} + 4'h3;
        end else begin
          r.dummy = (i == 2'h0) ? 4'h4 : {2'h0, i} + 4'h5;
        end
      OPC_DQIO, OPC_DQIO4: begin
        r.mode  = 4'h1;
        r.dummy = (i == 2'h0) ? 4'h3 : {2'h0, i} + 4'h5;
      end
      default: r.dummy = 4'h0;
    endcase
    r.pattern_ok = (r.dummy >= PATTERN_MIN_DUMMY);
    return r;
  endfunction

  // pins from outside pass two flops before use
  logic [1:0] sck_s_q, cs_s_q, din_s_q, wp_s_q, pause_s_q;
  logic       sck_prev_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      sck_s_q    <= 2'h0;
      cs_s_q     <= 2'h3;
      din_s_q    <= 2'h0;
      wp_s_q     <= 2'h3;
      pause_s_q  <= 2'h3;
      sck_prev_q <= 1'b0;
    end else begin
      sck_s_q    <= {sck_s_q[0], sck};
      cs_s_q     <= {cs_s_q[0], cs_n};
      din_s_q    <= {din_s_q[0], data_in};
      wp_s_q     <= {wp_s_q[0], write_protect_pin_n};
      pause_s_q  <= {pause_s_q[0], pause_pin_n};
      sck_prev_q <= sck_s_q[1];
    end
  end

  logic rise, fall, sel;
  assign rise = sck_s_q[1] & ~sck_prev_q;
  assign fall = ~sck_s_q[1] & sck_prev_q;
  assign sel  = ~cs_s_q[1];

  // serial link state
  link_state_t st_q;
  logic [4:0]  cnt_q;
  logic [15:0] shift_q;
  logic        wrr_done_q;
  logic        clear_status_cmd_done_q;
  logic [7:0]  out_q;

  always_ff @(posedge clock) begin
    if (rst || !sel) begin
      st_q        <= ST_OPC;
      cnt_q       <= 5'h0;
      shift_q     <= 16'h0;
      wrr_done_q  <= 1'b0;
      clear_status_cmd_done_q <= 1'b0;
    end else begin
      wrr_done_q  <= 1'b0;
      clear_status_cmd_done_q <= 1'b0;
      if (rise) begin
        shift_q <= {shift_q[14:0], din_s_q[1]};
        cnt_q   <= cnt_q + 5'h1;
        unique case (st_q)
          ST_OPC:
            if (cnt_q[2:0] == BITS_LAST[2:0]) begin
              cnt_q <= 5'h0;
              if ({shift_q[6:0], din_s_q[1]} == CLEAR_STATUS_OPC) begin
                clear_status_cmd_done_q <= 1'b1;
                st_q        <= ST_SKIP;
              end else if (busy_flag) begin
                st_q <= ST_SKIP;
              end else if ({shift_q[6:0], din_s_q[1]} == WRITE_REGS_OPC) begin
                st_q <= ST_DATA;
              end else if ({shift_q[6:0], din_s_q[1]} == READ_CFG_OPC) begin
                st_q <= ST_OUT;
              end else begin
                st_q <= ST_SKIP;
              end
            end
          ST_DATA:
            if (cnt_q == WRR_BITS - 5'h1) begin
              wrr_done_q <= 1'b1;
              st_q       <= ST_SKIP;
            end
          ST_OUT:  st_q <= ST_OUT;
          ST_SKIP: st_q <= ST_SKIP;
        endcase
      end
    end
  end

  // read-back of the register on the falling edges
  always_ff @(posedge clock) begin
    if (rst || !sel || st_q != ST_OUT) begin
      out_q       <= config_reg_one;
      data_out    <= 1'b0;
      data_out_en <= 1'b0;
    end else if (fall) begin
      data_out    <= out_q[7];
      data_out_en <= 1'b1;
      out_q       <= {out_q[6:0], out_q[7]};
    end
  end

  // the second data byte of the write lands in configuration_one
  logic [7:0] nv;
  logic       otp_fail;
  logic       frz;
  assign nv  = shift_q[7:0];
  assign frz = config_reg_one[FRZ_B];
  assign otp_fail = (config_reg_one[TBP_B] & ~nv[TBP_B])
                  | (config_reg_one[BPV_B] & ~nv[BPV_B])
                  | (config_reg_one[SST_B] & ~nv[SST_B] & ~UNIFORM);

  // non-volatile and one-time bits survive soft reset; rst clears them all, hw_reset clears only the freeze bit
  always_ff @(posedge clock) begin
    if (rst) begin
      config_reg_one <= CFG_RESET;
    end else if (hw_reset) begin
      config_reg_one[FRZ_B] <= 1'b0;
    end else if (wrr_done_q && !otp_fail) begin
      config_reg_one[LC_HI:LC_LO] <= nv[LC_HI:LC_LO];
      config_reg_one[QUAD_B]      <= nv[QUAD_B];
      config_reg_one[BPV_B]       <= nv[BPV_B];
      if (!frz) begin
        config_reg_one[TBP_B] <= nv[TBP_B];
        if (!UNIFORM)
          config_reg_one[SST_B] <= nv[SST_B];
      end
      config_reg_one[FRZ_B] <= frz | nv[FRZ_B];
    end
  end

  // protection range: rst loads zero; volatile copy (BPV set) goes to all-ones on hw or soft reset
  always_ff @(posedge clock) begin
    if (rst) begin
      protect_range_bits <= 3'h0;
    end else if ((hw_reset || soft_reset) && config_reg_one[BPV_B]) begin
      protect_range_bits <= PROT_VOL_RST;
    end else if (wrr_done_q && !frz && !otp_fail) begin
      protect_range_bits <= shift_q[12:10];
    end
  end

  // failed one-time clear raises the error; set wins over clear
  always_ff @(posedge clock) begin
    if (rst || hw_reset || soft_reset) begin
      program_error_flag <= 1'b0;
      busy_flag          <= 1'b0;
    end else if (wrr_done_q && otp_fail) begin
      program_error_flag <= 1'b1;
      busy_flag          <= 1'b1;
    end else if (clear_status_cmd_done_q) begin
      program_error_flag <= 1'b0;
      busy_flag          <= 1'b0;
    end
  end

  // latency result for the opcode the command decoder reports
  latency_t lat;
  assign lat = lookup(read_opcode, config_reg_one[LC_HI:LC_LO], ENHANCED);

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_cycles       <= 4'h0;
      dummy_cycles      <= 4'h0;
      pattern_allowed   <= 1'b0;
      protect_from_top  <= 1'b1;
      small_sectors_top <= 1'b0;
      wp_active         <= 1'b0;
      pause_active      <= 1'b0;
    end else begin
      mode_cycles       <= lat.mode;
      dummy_cycles      <= lat.dummy;
      pattern_allowed   <= lat.pattern_ok;
      protect_from_top  <= ~config_reg_one[TBP_B];
      small_sectors_top <= config_reg_one[SST_B] & ~UNIFORM;
      // in quad mode the pins are data lines, seen as inactive
      wp_active    <= ~config_reg_one[QUAD_B] & ~wp_s_q[1];
      pause_active <= ~config_reg_one[QUAD_B] & ~pause_s_q[1];
    end
  end

  property p_pattern;
    @(posedge clock) disable iff (rst)
      pattern_allowed |-> dummy_cycles >= 4'h5;
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern short");

  property p_hp_mode;
    @(posedge clock) disable iff (rst)
      (!ENHANCED && $past(read_opcode) == OPC_DIO && $past(!rst))
        |-> mode_cycles == 4'h0;
  endproperty
  a_hp_mode: assert property (p_hp_mode) else $error("hp mode");

  property p_tbp_sticky;
    @(posedge clock) disable iff (rst || hw_reset)
      config_reg_one[TBP_B] |=> config_reg_one[TBP_B];
  endproperty
  a_tbp_sticky: assert property (p_tbp_sticky) else $error("tbp cleared");

  property p_bpv_sticky;
    @(posedge clock) disable iff (rst || hw_reset)
      config_reg_one[BPV_B] |=> config_reg_one[BPV_B];
  endproperty
  a_bpv_sticky: assert property (p_bpv_sticky) else $error("bpv cleared");

  property p_freeze;
    @(posedge clock) disable iff (rst || hw_reset)
      (frz && !((hw_reset || soft_reset) && config_reg_one[BPV_B]))
        |=> $stable(protect_range_bits);
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen range moved");

  property p_frz_soft;
    @(posedge clock) disable iff (rst || hw_reset)
      frz |=> frz;
  endproperty
  a_frz_soft: assert property (p_frz_soft) else $error("freeze lost");

  property p_err_busy;
    @(posedge clock) disable iff (rst)
      program_error_flag |-> busy_flag;
  endproperty
  a_err_busy: assert property (p_err_busy) else $error("error not busy");

  // a busy device must drop a whole write, not land it
  property p_busy_lock;
    @(posedge clock) disable iff (rst)
      busy_flag |-> !wrr_done_q;
  endproperty
  a_busy_lock: assert property (p_busy_lock)
    else $error("write landed while busy");

  property p_quad;
    @(posedge clock) disable iff (rst)
      $past(config_reg_one[QUAD_B]) && $past(!rst)
        |-> !wp_active && !pause_active;
  endproperty
  a_quad: assert property (p_quad) else $error("quad pins active");

endmodule

//--- rtl/cfg_one_pkg.sv
// constants and types for the configuration-register-one block
package cfg_one_pkg;
  localparam logic [7:0] WRITE_REGS_OPC   = 8'h01;
  localparam logic [7:0] CLEAR_STATUS_OPC = 8'h30;
  localparam logic [7:0] READ_CFG_OPC     = 8'h35;
  // read opcodes
  localparam logic [7:0] OPC_READ   = 8'h03;
  localparam logic [7:0] OPC_READ4  = 8'h13;
  localparam logic [7:0] OPC_FAST   = 8'h0b;
  localparam logic [7:0] OPC_FAST4  = 8'h0c;
  localparam logic [7:0] OPC_DOUT   = 8'h3b;
  localparam logic [7:0] OPC_DOUT4  = 8'h3c;
  localparam logic [7:0] OPC_QOUT   = 8'h6b;
  localparam logic [7:0] OPC_QOUT4  = 8'h6c;
  localparam logic [7:0] OPC_DIO    = 8'hbb;
  localparam logic [7:0] OPC_DIO4   = 8'hbc;
  localparam logic [7:0] OPC_QIO    = 8'heb;
  localparam logic [7:0] OPC_QIO4   = 8'hec;
  localparam logic [7:0] OPC_DFAST  = 8'h0d;
  localparam logic [7:0] OPC_DFAST4 = 8'h0e;
  localparam logic [7:0] OPC_DDIO   = 8'hbd;
  localparam logic [7:0] OPC_DDIO4  = 8'hbe;
  localparam logic [7:0] OPC_DQIO   = 8'hed;
  localparam logic [7:0] OPC_DQIO4  = 8'hee;
  // field positions of configuration_one
  localparam int LC_HI  = 7;
  localparam int LC_LO  = 6;
  localparam int TBP_B  = 5;
  localparam int BPV_B  = 3;
  localparam int SST_B  = 2;
  localparam int QUAD_B = 1;
  localparam int FRZ_B  = 0;
  localparam logic [7:0] CFG_RESET    = 8'h00;
  localparam logic [2:0] PROT_VOL_RST = 3'h7;
  localparam logic [3:0] PATTERN_MIN_DUMMY = 4'h5;
  localparam logic [4:0] WRR_BITS    = 5'h10;
  localparam logic [3:0] BITS_LAST   = 4'h7;

  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] dummy;
    logic       pattern_ok;
  } latency_t;

  typedef enum logic [1:0] {
    ST_OPC  = 2'b00,
    ST_DATA = 2'b01,
    ST_OUT  = 2'b10,
    ST_SKIP = 2'b11
  } link_state_t;
endpackage
